// ==== pkg/ebpmw_pkg.sv ====
// Constants, register map and carrier types for the expansion bus pin mux.
// Assumes one 100 MHz clock and a synchronous active-low reset.
package ebpmw_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int REG_AW = 8;
  localparam logic [7:0] OFF_BUS_CONTROL_ONE = 8'h00;
  localparam logic [7:0] OFF_STROBE_ROUTING = 8'h04;
  localparam logic [7:0] OFF_LOW_ADDR_ROUTING = 8'h08;
  localparam logic [7:0] OFF_MID_ADDR_ROUTING = 8'h0C;
  localparam logic [7:0] OFF_UPPER_ADDR_ROUTING = 8'h10;
  localparam logic [7:0] OFF_TOP_ADDR_ROUTING = 8'h14;
  localparam logic [7:0] OFF_DATA_ROUTING = 8'h18;
  localparam logic [7:0] OFF_REGION_CONTROL = 8'h1C;
  localparam logic [7:0] OFF_REGION_BASE = 8'h20;
  localparam logic [7:0] OFF_REGION_MASK = 8'h24;
  localparam logic [7:0] OFF_STATUS = 8'h28;
  // Pad layout
  localparam int EXT_ADDR_LINES = 30;
  localparam int WIDE_ADDR_LINES = 22;
  localparam int EXT_DATA_LINES = 8;
  localparam int CS_LINES = 4;
  localparam int WR_LINES = 2;
  localparam int PAD_COUNT = 46;
  localparam int PAD_DATA = 30;
  localparam int PAD_HOLD = 45;
  localparam int PAD_CS = 38;
  localparam int PAD_WR = 42;
  localparam int PAD_OE = 44;
  // Field positions
  localparam int HOLD_ROUTE_BIT = 7;
  localparam int CS_ROUTE_LSB = 3;
  localparam int WR_ROUTE_LSB = 1;
  localparam int OE_ROUTE_BIT = 0;
  localparam int LOW_WR_LSB = 6;
  localparam int LOW_ADDR_LINES = 6;
  localparam int WIDE_BUS_BIT = 0;
  localparam int WAIT_LSB = 4;
  localparam int WAIT_W = 4;
  localparam logic [3:0] MODE_EXT8_BE = 4'h4;
  localparam int STATUS_BUSY_BIT = 8;
  localparam int STATUS_HOLD_BIT = 9;
  localparam int STATUS_ERR_BIT = 10;
  // Reset values
  localparam logic [7:0] RST_ROUTING = 8'h00;
  localparam logic [15:0] RST_REGION_CONTROL = 16'h0000;
  localparam logic [31:0] RST_REGION_BASE = 32'h0050_0000;
  localparam logic [31:0] RST_REGION_MASK = 32'h0007_FFFF;
  // Timing
  localparam int CLK_PERIOD_PS = 10000;
  localparam int CS_LEAD_PS = 33200;
  localparam int COUNT_W = 4;
  localparam logic [COUNT_W-1:0] CS_LEAD_CYCLES =
    COUNT_W'((CS_LEAD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [COUNT_W-1:0] MIN_WAITS = 4'h1;
  localparam logic [COUNT_W-1:0] FINISH_CYCLES = 4'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_STROBE = 2'b10,
    ST_FINISH = 2'b11
  } ebpmw_state_type;
  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic [7:0] wdata;
  } ebpmw_req_type;
  typedef struct packed {
    logic oe;
    logic [WR_LINES-1:0] wr;
    logic [CS_LINES-1:0] cs;
  } ebpmw_strobe_type;
endpackage

// ==== verilog/ebpmw_top.sv ====
// Expansion bus unit: AXI4-Lite registers, pin routing and the access sequencer.
// Assumes pads resolved outside; pad inputs are asynchronous to aclk.
`timescale 1ns/1ps
module ebpmw_top
  import ebpmw_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // On-chip memory requests
  input wire logic req_valid,
  input wire ebpmw_req_type req,
  output logic req_ready,
  output logic resp_valid,
  output logic [7:0] resp_rdata,
  output logic resp_error,
  // General-purpose I/O side
  input wire logic [PAD_COUNT-1:0] gpio_out,
  input wire logic [PAD_COUNT-1:0] gpio_oe,
  // Pads
  input wire logic [PAD_COUNT-1:0] pad_in,
  output logic [PAD_COUNT-1:0] pad_out,
  output logic [PAD_COUNT-1:0] pad_oe
);

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Registers
  logic [7:0] bus_control_one, next_bus_control_one;
  logic [7:0] strobe_pin_routing, next_strobe_pin_routing;
  logic [7:0] low_address_pin_routing, next_low_address_pin_routing;
  logic [7:0] mid_address_shared_pin_routing, next_mid_address_shared_pin_routing;
  logic [7:0] upper_address_pin_routing, next_upper_address_pin_routing;
  logic [7:0] top_address_pin_routing, next_top_address_pin_routing;
  logic [7:0] data_pin_routing, next_data_pin_routing;
  logic [15:0] external_region_control, next_external_region_control;
  logic [31:0] region_base, next_region_base;
  logic [31:0] region_mask, next_region_mask;
  // AXI state
  logic aw_held, next_aw_held;
  logic [REG_AW-1:0] aw_addr, next_aw_addr;
  logic w_held, next_w_held;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  // Access sequencer state
  ebpmw_state_type state, next_state;
  logic [COUNT_W-1:0] count, next_count;
  ebpmw_req_type cur, next_cur;
  logic next_req_ready, next_resp_valid, next_resp_error;
  logic [7:0] next_resp_rdata;
  logic last_error, next_last_error;
  // Pad state
  logic [PAD_COUNT-1:0] sync1, sync2;
  logic [PAD_COUNT-1:0] next_pad_out, next_pad_oe;

  logic hold_active;
  logic [COUNT_W-1:0] eff_waits;
  logic region_hit;
  logic [31:0] status_word;

  assign hold_active = strobe_pin_routing[HOLD_ROUTE_BIT] & sync2[PAD_HOLD];
  assign eff_waits = (external_region_control[WAIT_LSB +: WAIT_W] < MIN_WAITS) ?
                     MIN_WAITS : external_region_control[WAIT_LSB +: WAIT_W];
  assign region_hit = ((req.addr & ~region_mask) == (region_base & ~region_mask)) &&
                      (external_region_control[3:0] == MODE_EXT8_BE) &&
                      !bus_control_one[WIDE_BUS_BIT];
  assign status_word = {21'h000000, last_error, hold_active, state != ST_IDLE, resp_rdata};

  // Register bus
  always_comb begin
    logic [31:0] wv;
    logic wr_ok;
    wv = 32'h0000_0000;
    wr_ok = 1'b1;
    next_bus_control_one = bus_control_one;
    next_strobe_pin_routing = strobe_pin_routing;
    next_low_address_pin_routing = low_address_pin_routing;
    next_mid_address_shared_pin_routing = mid_address_shared_pin_routing;
    next_upper_address_pin_routing = upper_address_pin_routing;
    next_top_address_pin_routing = top_address_pin_routing;
    next_data_pin_routing = data_pin_routing;
    next_external_region_control = external_region_control;
    next_region_base = region_base;
    next_region_mask = region_mask;
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr[REG_AW-1:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (next_aw_held && next_w_held && !next_bvalid) begin
      if (next_aw_addr == OFF_BUS_CONTROL_ONE) begin
        wv = merge_strb({24'h000000, bus_control_one}, next_w_data, next_w_strb);
        next_bus_control_one = wv[7:0];
      end else if (next_aw_addr == OFF_STROBE_ROUTING) begin
        wv = merge_strb({24'h000000, strobe_pin_routing}, next_w_data, next_w_strb);
        next_strobe_pin_routing = wv[7:0];
      end else if (next_aw_addr == OFF_LOW_ADDR_ROUTING) begin
        wv = merge_strb({24'h000000, low_address_pin_routing}, next_w_data, next_w_strb);
        next_low_address_pin_routing = wv[7:0];
      end else if (next_aw_addr == OFF_MID_ADDR_ROUTING) begin
        wv = merge_strb({24'h000000, mid_address_shared_pin_routing}, next_w_data,
                        next_w_strb);
        next_mid_address_shared_pin_routing = wv[7:0];
      end else if (next_aw_addr == OFF_UPPER_ADDR_ROUTING) begin
        wv = merge_strb({24'h000000, upper_address_pin_routing}, next_w_data, next_w_strb);
        next_upper_address_pin_routing = wv[7:0];
      end else if (next_aw_addr == OFF_TOP_ADDR_ROUTING) begin
        wv = merge_strb({24'h000000, top_address_pin_routing}, next_w_data, next_w_strb);
        next_top_address_pin_routing = wv[7:0];
      end else if (next_aw_addr == OFF_DATA_ROUTING) begin
        wv = merge_strb({24'h000000, data_pin_routing}, next_w_data, next_w_strb);
        next_data_pin_routing = wv[7:0];
      end else if (next_aw_addr == OFF_REGION_CONTROL) begin
        wv = merge_strb({16'h0000, external_region_control}, next_w_data, next_w_strb);
        next_external_region_control = wv[15:0];
      end else if (next_aw_addr == OFF_REGION_BASE) begin
        next_region_base = merge_strb(region_base, next_w_data, next_w_strb);
      end else if (next_aw_addr == OFF_REGION_MASK) begin
        next_region_mask = merge_strb(region_mask, next_w_data, next_w_strb);
      end else if (next_aw_addr != OFF_STATUS) begin
        wr_ok = 1'b0;
      end else begin
        wr_ok = 1'b1;
      end
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      if (s_axi_araddr[REG_AW-1:0] == OFF_BUS_CONTROL_ONE) begin
        next_rdata = {24'h000000, bus_control_one};
      end else if (s_axi_araddr[REG_AW-1:0] == OFF_STROBE_ROUTING) begin
        next_rdata = {24'h000000, strobe_pin_routing};
      end else if (s_axi_araddr[REG_AW-1:0] == OFF_LOW_ADDR_ROUTING) begin
        next_rdata = {24'h000000, low_address_pin_routing};
      end else if (s_axi_araddr[REG_AW-1:0] == OFF_MID_ADDR_ROUTING) begin
        next_rdata = {24'h000000, mid_address_shared_pin_routing};
      end else if (s_axi_araddr[REG_AW-1:0] == OFF_UPPER_ADDR_ROUTING) begin
        next_rdata = {24'h000000, upper_address_pin_routing};
      end else if (s_axi_araddr[REG_AW-1:0] == OFF_TOP_ADDR_ROUTING) begin
        next_rdata = {24'h000000, top_address_pin_routing};
      end else if (s_axi_araddr[REG_AW-1:0] == OFF_DATA_ROUTING) begin
        next_rdata = {24'h000000, data_pin_routing};
      end else if (s_axi_araddr[REG_AW-1:0] == OFF_REGION_CONTROL) begin
        next_rdata = {16'h0000, external_region_control};
      end else if (s_axi_araddr[REG_AW-1:0] == OFF_REGION_BASE) begin
        next_rdata = region_base;
      end else if (s_axi_araddr[REG_AW-1:0] == OFF_REGION_MASK) begin
        next_rdata = region_mask;
      end else if (s_axi_araddr[REG_AW-1:0] == OFF_STATUS) begin
        next_rdata = status_word;
      end else begin
        next_rdata = 32'h0000_0000;
        next_rresp = RESP_SLVERR;
      end
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_control_one <= RST_ROUTING;
      strobe_pin_routing <= RST_ROUTING;
      low_address_pin_routing <= RST_ROUTING;
      mid_address_shared_pin_routing <= RST_ROUTING;
      upper_address_pin_routing <= RST_ROUTING;
      top_address_pin_routing <= RST_ROUTING;
      data_pin_routing <= RST_ROUTING;
      external_region_control <= RST_REGION_CONTROL;
      region_base <= RST_REGION_BASE;
      region_mask <= RST_REGION_MASK;
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      bus_control_one <= next_bus_control_one;
      strobe_pin_routing <= next_strobe_pin_routing;
      low_address_pin_routing <= next_low_address_pin_routing;
      mid_address_shared_pin_routing <= next_mid_address_shared_pin_routing;
      upper_address_pin_routing <= next_upper_address_pin_routing;
      top_address_pin_routing <= next_top_address_pin_routing;
      data_pin_routing <= next_data_pin_routing;
      external_region_control <= next_external_region_control;
      region_base <= next_region_base;
      region_mask <= next_region_mask;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // Access sequencer
  always_comb begin
    next_state = state;
    next_count = count;
    next_cur = cur;
    next_req_ready = req_ready;
    next_resp_valid = 1'b0;
    next_resp_error = resp_error;
    next_resp_rdata = resp_rdata;
    next_last_error = last_error;
    case (state)
      ST_IDLE: begin
        next_req_ready = 1'b1;
        if (req_valid && req_ready) begin
          if (region_hit) begin
            next_cur = req;
            next_state = ST_LEAD;
            next_count = CS_LEAD_CYCLES - MIN_WAITS;
            next_req_ready = 1'b0;
          end else begin
            next_resp_valid = 1'b1;
            next_resp_error = 1'b1;
            next_last_error = 1'b1;
          end
        end
      end
      ST_LEAD: begin
        if (count == '0) begin
          next_state = ST_STROBE;
          next_count = eff_waits - MIN_WAITS;
        end else begin
          next_count = count - MIN_WAITS;
        end
      end
      ST_STROBE: begin
        if (count != '0) begin
          next_count = count - MIN_WAITS;
        end else if (!hold_active) begin
          next_state = ST_FINISH;
          next_count = FINISH_CYCLES - MIN_WAITS;
        end
      end
      ST_FINISH: begin
        if (count == '0) begin
          next_state = ST_IDLE;
          next_req_ready = 1'b1;
          next_resp_valid = 1'b1;
          next_resp_error = 1'b0;
          next_last_error = 1'b0;
          if (!cur.write) begin
            next_resp_rdata = sync2[PAD_DATA +: EXT_DATA_LINES];
          end
        end else begin
          next_count = count - MIN_WAITS;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      count <= '0;
      cur <= '0;
      req_ready <= 1'b0;
      resp_valid <= 1'b0;
      resp_error <= 1'b0;
      resp_rdata <= 8'h00;
      last_error <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      cur <= next_cur;
      req_ready <= next_req_ready;
      resp_valid <= next_resp_valid;
      resp_error <= next_resp_error;
      resp_rdata <= next_resp_rdata;
      last_error <= next_last_error;
    end
  end

  // Pin routing
  always_comb begin
    logic [PAD_COUNT-1:0] route;
    logic [PAD_COUNT-1:0] bus_val;
    logic [PAD_COUNT-1:0] bus_en;
    ebpmw_strobe_type stb;
    route = '0;
    stb = '0;
    stb.cs[0] = (state != ST_IDLE);
    stb.oe = (state == ST_STROBE) && !cur.write;
    stb.wr[0] = (state == ST_STROBE) && cur.write;
    route[LOW_ADDR_LINES-1:0] = low_address_pin_routing[LOW_ADDR_LINES-1:0];
    route[13:LOW_ADDR_LINES] = mid_address_shared_pin_routing;
    route[21:14] = upper_address_pin_routing;
    route[29:22] = bus_control_one[WIDE_BUS_BIT] ? 8'h00 : top_address_pin_routing;
    route[PAD_DATA +: EXT_DATA_LINES] = data_pin_routing;
    route[PAD_CS +: CS_LINES] = strobe_pin_routing[CS_ROUTE_LSB +: CS_LINES];
    route[PAD_WR +: WR_LINES] = strobe_pin_routing[WR_ROUTE_LSB +: WR_LINES] |
                            low_address_pin_routing[LOW_WR_LSB +: WR_LINES];
    route[PAD_OE] = strobe_pin_routing[OE_ROUTE_BIT];
    route[PAD_HOLD] = strobe_pin_routing[HOLD_ROUTE_BIT];
    bus_val = {1'b0, ~stb, cur.wdata, cur.addr[EXT_ADDR_LINES-1:0]};
    bus_en = {1'b0, {7{1'b1}}, {EXT_DATA_LINES{cur.write && state != ST_IDLE}},
              {EXT_ADDR_LINES{1'b1}}};
    for (int i = 0; i < PAD_COUNT; i++) begin
      next_pad_out[i] = route[i] ? bus_val[i] : gpio_out[i];
      next_pad_oe[i] = route[i] ? bus_en[i] : gpio_oe[i];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '0;
      sync2 <= '0;
      pad_out <= '0;
      pad_oe <= '0;
    end else begin
      sync1 <= pad_in;
      sync2 <= sync1;
      pad_out <= next_pad_out;
      pad_oe <= next_pad_oe;
    end
  end

endmodule

// ==== verification/ebpmw_top_asserts.sv ====
// Port-level checker for the expansion bus pin mux top.
// Assumes the bench holds gpio_out high, so strobe pads fall only when routed.
`timescale 1ns/1ps
module ebpmw_top_asserts
  import ebpmw_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  // Memory requests
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic resp_valid,
  // Pads
  input wire logic [PAD_COUNT-1:0] gpio_oe,
  input wire logic [PAD_COUNT-1:0] pad_out,
  input wire logic [PAD_COUNT-1:0] pad_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic cs_low;
  assign cs_low = pad_oe[PAD_CS] && !pad_out[PAD_CS];
  sequence cs_led_s;
    $past(cs_low, 4) && !$past(cs_low, 5);
  endsequence
  sequence no_resp_s;
    (!resp_valid) [*6];
  endsequence
  AST_BVALID_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped early");
  AST_RVALID_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped early");
  AST_AW_REFUSED: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("awready during bvalid");
  AST_AR_REFUSED: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during rvalid");
  AST_RESP_PULSE: assert property (resp_valid |=> !resp_valid)
    else $error("resp_valid longer than one cycle");
  AST_REQ_REFUSED: assert property (req_valid && req_ready |=> !req_ready || resp_valid)
    else $error("request taken while busy");
  AST_CS_LEAD_OE: assert property ($fell(pad_out[PAD_OE]) && pad_oe[PAD_OE] |-> cs_led_s)
    else $error("chip select lead before output enable wrong");
  AST_CS_LEAD_WR: assert property ($fell(pad_out[PAD_WR]) && pad_oe[PAD_WR] |-> cs_led_s)
    else $error("chip select lead before write strobe wrong");
  AST_OE_IN_CS: assert property (pad_oe[PAD_CS] && pad_oe[PAD_OE] &&
    !pad_out[PAD_OE] |-> cs_low)
    else $error("output enable outside chip select");
  AST_MIN_FETCH: assert property ($rose(cs_low) |-> no_resp_s)
    else $error("external access too short");
  AST_HOLD_UNDRIVEN: assert property (pad_oe[45] |-> $past(gpio_oe[45]))
    else $error("hold pad driven by bus unit");
endmodule
bind ebpmw_top ebpmw_top_asserts u_chk (.*);

// ==== verification/ebpmw_sram.sv ====
// Byte-wide asynchronous memory model on the expansion bus pads.
// Assumes chip select 0, write strobe 0 and output enable pads, all active low.
`timescale 1ns/1ps
module ebpmw_sram
  import ebpmw_pkg::*;
#(
  parameter int HOLD_CYCLES = 8
)
(
  // Clock
  input wire logic aclk,
  // Pads from the bus unit
  input wire logic [PAD_COUNT-1:0] pad_out,
  input wire logic [PAD_COUNT-1:0] pad_oe,
  // Stretch enable
  input wire logic stretch_en,
  // Resolved pad levels
  output logic [PAD_COUNT-1:0] pad_in
);
  logic [7:0] mem [16];
  logic [7:0] last;
  int sel_cnt;
  logic sel, rd, hold;
  assign sel = pad_oe[PAD_CS] && !pad_out[PAD_CS];
  assign rd = sel && pad_oe[PAD_OE] && !pad_out[PAD_OE];
  assign hold = stretch_en && sel && sel_cnt < HOLD_CYCLES;
  always_ff @(posedge aclk) begin
    if (sel && pad_oe[PAD_WR] && !pad_out[PAD_WR]) mem[pad_out[3:0]] <= pad_out[37:30];
    last <= pad_in[37:30];
    sel_cnt <= sel ? sel_cnt + 1 : 0;
  end
  // Released data lines show the inverse of the last level
  always_comb begin
    pad_in = pad_out;
    pad_in[PAD_HOLD] = hold;
    if (rd) pad_in[37:30] = mem[pad_out[3:0]];
    else if (!pad_oe[30]) pad_in[37:30] = ~last;
  end
endmodule

// ==== verification/ebpmw_top_bench.sv ====
// Self-checking bench: register bus tasks, memory request tasks, memory model.
// Assumes the checker is bound to the top by its own file.
`timescale 1ns/1ps
module ebpmw_top_bench;
  import ebpmw_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, req_ready, resp_valid, resp_error, req_valid = 0, stretch_en = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  ebpmw_req_type req = '0;
  logic [7:0] resp_rdata;
  logic [PAD_COUNT-1:0] gpio_out = '1, gpio_oe = 46'h1555_5555_5555;
  logic [PAD_COUNT-1:0] pad_in, pad_out, pad_oe;
  int err_count = 0, check_count = 0, cycles = 0;
  logic [7:0] cfg [8] = '{8'h00, 8'h7F, 8'h3F, 8'hFF, 8'h1F, 8'h00, 8'hFF, 8'h04};
  logic [3:0] wv [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'hF};
  ebpmw_top dut (.*);
  ebpmw_sram #(.HOLD_CYCLES(8)) u_mem (.aclk(aclk), .pad_out(pad_out), .pad_oe(pad_oe),
    .stretch_en(stretch_en), .pad_in(pad_in));
  always #5 aclk = ~aclk;
  task automatic tally_and_finish();
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= {24'h000000, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    while (s_axi_awvalid || s_axi_wvalid || s_axi_bvalid !== 1'b1) begin
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      @(posedge aclk);
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= {24'h000000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    while (s_axi_arvalid || s_axi_rvalid !== 1'b1) begin
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      @(posedge aclk);
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic mem(input logic [31:0] a, input logic w, input logic [7:0] d,
    output logic [7:0] q, output logic e, output int n);
    @(posedge aclk);
    req_valid <= 1'b1;
    req <= '{addr: a, write: w, wdata: d};
    @(posedge aclk);
    while (req_ready !== 1'b1) @(posedge aclk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (resp_valid !== 1'b1);
    q = resp_rdata;
    e = resp_error;
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] q;
    logic e;
    int n, w;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      axi_rd(8'(i * 4), d, r);
      chk("reset value", 64'h0, d);
    end
    axi_rd(OFF_REGION_BASE, d, r);
    chk("region base", 64'h0050_0000, d);
    axi_rd(OFF_REGION_MASK, d, r);
    chk("region mask", 64'h0007_FFFF, d);
    axi_rd(8'h30, d, r);
    chk("unmapped resp", {RESP_SLVERR, 32'h0000_0000}, {r, d});
    chk("pad oe idle", gpio_oe, pad_oe);
    chk("pad out idle", gpio_out, pad_out);
    for (int i = 0; i < 8; i++) begin
      axi_wr(8'(i * 4), {24'h000000, cfg[i]}, r);
      chk("write resp", RESP_OKAY, r);
      axi_rd(8'(i * 4), d, r);
      chk("routing readback", cfg[i], d);
    end
    repeat (3) @(posedge aclk);
    chk("routed pad oe", {gpio_oe[45], 15'h7F00, gpio_oe[29:19], 19'h7FFFF}, pad_oe);
    foreach (wv[k]) begin
      w = (wv[k] == 4'h0) ? 1 : wv[k];
      axi_wr(OFF_REGION_CONTROL, {24'h000000, wv[k], 4'h4}, r);
      mem(32'h0050_0000 + k, 1'b1, 8'hA0 + 8'(k), q, e, n);
      chk("write cycles", w + 8, n);
      mem(32'h0050_0000 + k, 1'b0, 8'h00, q, e, n);
      chk("read cycles", w + 8, n);
      chk("read data", {8'hA0 + 8'(k), 1'b0}, {q, e});
    end
    mem(32'h0058_0000, 1'b0, 8'h00, q, e, n);
    chk("miss", {1'b1, 32'h1}, {e, 32'(n)});
    axi_wr(OFF_REGION_CONTROL, 32'h0000_0000, r);
    mem(32'h0050_0001, 1'b0, 8'h00, q, e, n);
    chk("region off", 1'b1, e);
    axi_wr(OFF_REGION_CONTROL, 32'h0000_0014, r);
    axi_wr(OFF_BUS_CONTROL_ONE, 32'h0000_0001, r);
    mem(32'h0050_0001, 1'b0, 8'h00, q, e, n);
    chk("wide bus", 1'b1, e);
    axi_wr(OFF_BUS_CONTROL_ONE, 32'h0000_0000, r);
    axi_wr(OFF_STROBE_ROUTING, 32'h0000_00FF, r);
    stretch_en <= 1'b1;
    mem(32'h0050_0002, 1'b0, 8'h00, q, e, n);
    chk("hold pad oe", 1'b0, pad_oe[45]);
    chk("stretched", {1'b1, 8'hA2}, {n > 9, q});
    tally_and_finish();
  end
endmodule
